// File: rtl/srsp_pkg.sv
package srsp_pkg;
  // opcodes
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_PROT_B0 = 8'h3D;
  localparam logic [7:0] OP_PROT_B1 = 8'h2A;
  localparam logic [7:0] OP_PROT_B2 = 8'h7F;
  localparam logic [7:0] OP_PROT_EN = 8'hA9;
  localparam logic [7:0] OP_PROT_DIS = 8'h9A;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_SW_RESET = 8'hF0;
  localparam logic [7:0] OP_LOCKDOWN = 8'h3D;
  localparam logic [7:0] OP_FREEZE = 8'h34;
  localparam logic [7:0] OP_SEC_PROG = 8'h9B;
  localparam logic [7:0] OP_XFER_B1 = 8'h53;
  localparam logic [7:0] OP_XFER_B2 = 8'h55;
  localparam logic [7:0] OP_CMP_B1 = 8'h60;
  localparam logic [7:0] OP_CMP_B2 = 8'h61;
  localparam logic [7:0] OP_DPD_ENTER = 8'hB9;
  localparam logic [7:0] OP_DPD_LEAVE = 8'hAB;
  localparam logic [7:0] OP_UDPD_ENTER = 8'h79;
  localparam logic [7:0] OP_LOCK_B1 = 8'h7F;
  localparam logic [7:0] OP_LOCK_B3 = 8'h30;
  localparam logic [7:0] OP_FRZ_B3 = 8'hC1;
  localparam logic [7:0] OP_SEC_B3 = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESUME_LATENCY_NS = 50000;
  localparam int RESUME_CYCLES = RESUME_LATENCY_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_DIV = 10;
  // status word bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_PROT = 1;
  localparam int ST_PS1 = 2;
  localparam int ST_PS2 = 3;
  localparam int ST_ES = 4;
  localparam int ST_REJ = 5;
  localparam int ST_W = 8;
  // host register map
  localparam logic [3:0] RA_CMD = 4'h0;
  localparam logic [3:0] RA_LEN = 4'h1;
  localparam logic [3:0] RA_STAT = 4'h2;
  localparam logic [3:0] RA_IRQ = 4'h3;
  localparam logic [3:0] RA_MASK = 4'h4;
  localparam logic [3:0] RA_RXD = 4'h5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_W = 1;
endpackage : srsp_pkg

// File: rtl/srsp_link_if.sv
`timescale 1ns/1ps
interface srsp_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic wp_n_in;
  logic wp_n_oe;
  logic wp_n_out;
  logic rst_pin_n;
  modport dev (
    input sck, cs_n, mosi, rst_pin_n, wp_n_in,
    output miso
  );
  modport host (
    output sck, cs_n, mosi, rst_pin_n, wp_n_oe, wp_n_out,
    input miso
  );
endinterface : srsp_link_if

// File: rtl/srsp_dev.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module srsp_dev
  import srsp_pkg::*;
#(
  parameter int RESUME_CNT = RESUME_CYCLES,
  parameter int SECTORS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link
  srsp_link_if.dev link,
  // core side: suspend state and sector checks
  input wire logic core_suspend_b1,
  input wire logic core_suspend_b2,
  input wire logic core_suspend_er,
  input wire logic [SECTORS-1:0] prot_map,
  input wire logic [$clog2(SECTORS)-1:0] chk_sector,
  output logic chk_blocked,
  output logic [ST_W-1:0] status,
  output logic cmd_pulse,
  output logic [7:0] cmd_op,
  output logic cmd_accepted,
  output logic soft_reset,
  output logic pd_enter,
  output logic pd_leave
);
  typedef enum logic [1:0] {
    SRSP_IDLE = 2'b00,
    SRSP_RUN = 2'b01,
    SRSP_DONE = 2'b10
  } srsp_rs_t;

  logic [2:0] sck_s, cs_s, mosi_s, wp_s, rp_s;
  logic sck_rise, cs_rise, cs_low, wp_asserted, pin_rst;
  logic [7:0] sh;
  logic [2:0] bitc;
  logic [2:0] nbytes;
  logic [7:0] b0, b1, b2, b3;
  logic prot_sw;
  logic ps1, ps2, es;
  logic rej;
  srsp_rs_t rs;
  logic [$clog2(RESUME_CNT+1)-1:0] rcnt;
  logic any_susp;

  // two flops on every pin before use; stage 2 feeds edge detect
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 3'h0;
      wp_s <= 3'h7;
      rp_s <= 3'h7;
    end else begin
      sck_s <= {sck_s[1:0], link.sck};
      cs_s <= {cs_s[1:0], link.cs_n};
      mosi_s <= {mosi_s[1:0], link.mosi};
      wp_s <= {wp_s[1:0], link.wp_n_in};
      rp_s <= {rp_s[1:0], link.rst_pin_n};
    end
  end
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign cs_low = ~cs_s[1];
  // floating pin is pulled up where the link is wired, not in the interface, so low means asserted
  assign wp_asserted = ~wp_s[1];
  assign pin_rst = ~rp_s[1];
  assign any_susp = ps1 | ps2 | es;

  // byte capture, first four bytes kept; later bytes only counted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sh <= 8'h00;
      bitc <= 3'h0;
      nbytes <= 3'h0;
      {b0, b1, b2, b3} <= 32'h0000_0000;
    end else if (!cs_low) begin
      bitc <= 3'h0;
      if (cs_rise) begin
        nbytes <= 3'h0;
      end
    end else if (sck_rise) begin
      sh <= {sh[6:0], mosi_s[1]};
      bitc <= bitc + 3'h1;
      if (bitc == 3'h7) begin
        case (nbytes)
          3'h0: b0 <= {sh[6:0], mosi_s[1]};
          3'h1: b1 <= {sh[6:0], mosi_s[1]};
          3'h2: b2 <= {sh[6:0], mosi_s[1]};
          3'h3: b3 <= {sh[6:0], mosi_s[1]};
          default: ;
        endcase
        // saturate so a long frame cannot wrap back to four
        if (nbytes != 3'h7) begin
          nbytes <= nbytes + 3'h1;
        end
      end
    end
  end

  // command classification at chip select release
  logic is_prot_hdr, is_en, is_dis, refused, is_susp, is_rsm;
  always_comb begin
    is_prot_hdr = (b0 == OP_PROT_B0) && (b1 == OP_PROT_B1) &&
                  (b2 == OP_PROT_B2) && (nbytes == 3'h4);
    is_en = is_prot_hdr && (b3 == OP_PROT_EN);
    is_dis = is_prot_hdr && (b3 == OP_PROT_DIS);
    is_rsm = (b0 == OP_RESUME) && (nbytes != 3'h0);
    is_susp = (b0 == OP_SUSPEND) && (nbytes != 3'h0);
    refused = 1'b0;
    if (any_susp) begin
      // lockdown is matched on the 3D/2A/7F head; freeze and security program on the first byte alone
      if ((b0 == OP_LOCKDOWN) && (b1 == OP_PROT_B1) &&
          (b2 == OP_LOCK_B1)) begin
        refused = 1'b1;
      end
      if ((b0 == OP_SEC_PROG) || (b0 == OP_FREEZE)) begin
        refused = 1'b1;
      end
      if ((b0 == OP_DPD_ENTER) || (b0 == OP_DPD_LEAVE) ||
          (b0 == OP_UDPD_ENTER)) begin
        refused = 1'b1;
      end
    end
    if (ps1 && ((b0 == OP_XFER_B1) || (b0 == OP_CMP_B1))) begin
      refused = 1'b1;
    end
    if (ps2 && ((b0 == OP_XFER_B2) || (b0 == OP_CMP_B2))) begin
      refused = 1'b1;
    end
    // a suspend that lands while a resume is still running is dropped
    if (is_susp && (rs == SRSP_RUN)) begin
      refused = 1'b1;
    end
    // reads are never in the refused set above, so they always pass
  end

  // command outcome strobes, one cycle after release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_pulse <= 1'b0;
      cmd_op <= 8'h00;
      cmd_accepted <= 1'b0;
      soft_reset <= 1'b0;
      pd_enter <= 1'b0;
      pd_leave <= 1'b0;
      rej <= 1'b0;
    end else begin
      cmd_pulse <= cs_rise && (nbytes != 3'h0);
      cmd_op <= cs_rise ? b0 : cmd_op;
      cmd_accepted <= cs_rise && (nbytes != 3'h0) && !refused;
      soft_reset <= (cs_rise && (b0 == OP_SW_RESET)) || pin_rst;
      pd_enter <= cs_rise && !refused &&
                  ((b0 == OP_DPD_ENTER) || (b0 == OP_UDPD_ENTER));
      pd_leave <= cs_rise && !refused && (b0 == OP_DPD_LEAVE);
      if (cs_rise && (nbytes != 3'h0)) begin
        rej <= refused;
      end
    end
  end

  // software protection; power-up value off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prot_sw <= 1'b0;
    end else if (cs_rise && !any_susp) begin
      if (is_en) begin
        prot_sw <= 1'b1;
      end else if (is_dis && !wp_asserted) begin
        prot_sw <= 1'b0;
      end
    end
  end

  // suspend flags and the resume timer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ps1 <= 1'b0;
      ps2 <= 1'b0;
      es <= 1'b0;
      rs <= SRSP_IDLE;
      rcnt <= '0;
    end else if (pin_rst || (cs_rise && b0 == OP_SW_RESET)) begin
      ps1 <= 1'b0;
      ps2 <= 1'b0;
      es <= 1'b0;
      rs <= SRSP_IDLE;
    end else begin
      // core reports new suspends; ignored while resuming
      if (rs != SRSP_RUN) begin
        ps1 <= ps1 | core_suspend_b1;
        ps2 <= ps2 | core_suspend_b2;
        es <= es | core_suspend_er;
      end
      case (rs)
        SRSP_IDLE: begin
          if (cs_rise && is_rsm && any_susp) begin
            rs <= SRSP_RUN;
            rcnt <= RESUME_CNT[$bits(rcnt)-1:0];
            // a suspend reported in the same cycle wins over the clear
            if (ps1) begin
              ps1 <= core_suspend_b1;
            end else if (ps2) begin
              ps2 <= core_suspend_b2;
            end else begin
              es <= core_suspend_er;
            end
          end
        end
        SRSP_RUN: begin
          if (rcnt <= 1) begin
            rs <= SRSP_DONE;
          end else begin
            rcnt <= rcnt - 1'b1;
          end
        end
        SRSP_DONE: rs <= SRSP_IDLE;
        default: rs <= SRSP_IDLE;
      endcase
    end
  end

  // status word and sector check
  always_comb begin
    status = '0;
    status[ST_BUSY] = (rs == SRSP_RUN);
    status[ST_PROT] = prot_sw | wp_asserted;
    status[ST_PS1] = ps1;
    status[ST_PS2] = ps2;
    status[ST_ES] = es;
    status[ST_REJ] = rej;
  end
  assign chk_blocked = status[ST_PROT] & prot_map[chk_sector];

  // status byte shifted out on the falling sck phase
  logic [7:0] tx;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx <= 8'h00;
    end else if (!cs_low) begin
      tx <= status;
    end else if (sck_s[2] & ~sck_s[1]) begin
      tx <= {tx[6:0], tx[7]};
    end
  end
  assign link.miso = tx[7];
endmodule : srsp_dev

// File: rtl/srsp_host.sv
`timescale 1ns/1ps
module srsp_host
  import srsp_pkg::*;
#(
  parameter int HALF_DIV = SCK_HALF_DIV
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link
  srsp_link_if.host link,
  // software port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins held by software, and the interrupt line
  input wire logic wp_drive,
  input wire logic pin_reset,
  output logic irq
);
  typedef enum logic [1:0] {
    SRSPH_IDLE = 2'b00,
    SRSPH_SHIFT = 2'b01,
    SRSPH_END = 2'b10
  } srsph_st_t;

  srsph_st_t st;
  logic [31:0] cmd;
  logic [2:0] len;
  logic [7:0] rx;
  logic [IRQ_W-1:0] ists, imask;
  logic [$clog2(HALF_DIV+1)-1:0] div;
  logic [5:0] bits;
  logic sck_q, tick, done_ev;
  logic [1:0] miso_s;

  // divider gives the half-period enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div <= '0;
    end else if (st == SRSPH_IDLE || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = (div == HALF_DIV[$bits(div)-1:0] - 1'b1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      miso_s <= 2'b00;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  // frame engine, mode 0; frame ends exactly after len bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= SRSPH_IDLE;
      sck_q <= 1'b0;
      bits <= 6'h00;
      rx <= 8'h00;
      cmd <= 32'h0000_0000;
    end else begin
      case (st)
        SRSPH_IDLE: begin
          if (wr && addr == RA_CMD && len != 3'h0) begin
            cmd <= wdata;
            bits <= {len, 3'b000};
            st <= SRSPH_SHIFT;
          end
        end
        SRSPH_SHIFT: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
              cmd <= {cmd[30:0], 1'b0};
              bits <= bits - 6'h01;
              if (bits == 6'h01) begin
                st <= SRSPH_END;
              end
            end else begin
              rx <= {rx[6:0], miso_s[1]};
            end
          end
        end
        SRSPH_END: begin
          if (tick) begin
            st <= SRSPH_IDLE;
          end
        end
        default: st <= SRSPH_IDLE;
      endcase
    end
  end
  assign done_ev = (st == SRSPH_END) && tick;

  // length, mask and sticky status; set beats clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      len <= 3'h1;
      imask <= '0;
      ists <= '0;
    end else begin
      if (wr && addr == RA_LEN) len <= wdata[2:0];
      if (wr && addr == RA_MASK) imask <= wdata[IRQ_W-1:0];
      ists <= (ists & ~((wr && addr == RA_IRQ) ? wdata[IRQ_W-1:0] : '0))
              | {done_ev};
    end
  end
  assign irq = |(ists & imask);

  // read port, data the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        RA_LEN: rdata <= {29'h0, len};
        RA_STAT: rdata <= {31'h0, st != SRSPH_IDLE};
        RA_IRQ: rdata <= {{(32-IRQ_W){1'b0}}, ists};
        RA_MASK: rdata <= {{(32-IRQ_W){1'b0}}, imask};
        RA_RXD: rdata <= {24'h0, rx};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = (st == SRSPH_IDLE);
  assign link.mosi = cmd[31];
  assign link.wp_n_oe = wp_drive;
  assign link.wp_n_out = 1'b0;
  assign link.rst_pin_n = ~pin_reset;
endmodule : srsp_host

// File: dv/srsp_link_checker.sv
`timescale 1ns/1ps
module srsp_link_checker #(
  parameter int HALF_DIV = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link wires
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wp_n_in,
  input wire logic wp_n_oe,
  input wire logic wp_n_out,
  input wire logic rst_pin_n
);
  logic sck_q;
  logic [15:0] hcnt;
  logic [7:0] rises;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // cycles since the serial clock last changed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      hcnt <= 16'h0000;
    end else begin
      sck_q <= sck;
      hcnt <= (sck != sck_q) ? 16'h0000 : hcnt + 16'h0001;
    end
  end

  // rising clock edges inside the current frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rises <= 8'h00;
    end else if (cs_n) begin
      rises <= 8'h00;
    end else if (sck && !sck_q) begin
      rises <= rises + 8'h01;
    end
  end

  a_idle_clock_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_high_phase_len: assert property (
    $fell(sck) && !cs_n |-> hcnt == HALF_DIV - 1)
    else $error("serial clock high phase has wrong length");
  a_mosi_holds_high: assert property (
    sck && $past(sck) |-> $stable(mosi))
    else $error("data line moved while clock high");
  a_whole_bytes: assert property (
    $rose(cs_n) |-> rises[2:0] == 3'h0 && rises != 8'h00 && rises <= 8'h20)
    else $error("frame did not carry whole bytes");
  a_release_clock_low: assert property (
    $rose(cs_n) |-> !sck && !$past(sck))
    else $error("select released with clock high");
  a_select_held: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select dropped too soon");
  a_wp_drives_low: assert property (wp_n_oe |-> !wp_n_out)
    else $error("write protect driven high");
  a_reset_no_frame: assert property (!rst_pin_n |-> cs_n)
    else $error("frame open during pin reset");
endmodule : srsp_link_checker

// File: dv/test_suspend_resume_sector_protect_cmds.sv
`timescale 1ns/1ps
module test_suspend_resume_sector_protect_cmds
  import srsp_pkg::*;
;
  typedef struct packed {
    logic [2:0] susp;
    logic wp;
    logic [2:0] len;
    logic [31:0] w;
    logic [7:0] msk;
    logic [7:0] val;
    logic [1:0] ac;
  } srsp_row_t;
  localparam int RES_CNT = 400;
  // susp {er,b2,b1}; ac[1] checks acceptance, ac[0] expected
  srsp_row_t rows [21] = '{
    '{3'h0, 1'b0, 3'h4, 32'h3D2A7FA9, 8'h02, 8'h02, 2'h3},
    '{3'h0, 1'b1, 3'h4, 32'h3D2A7F9A, 8'h02, 8'h02, 2'h0},
    '{3'h0, 1'b0, 3'h3, 32'h3D2A7F9A, 8'h02, 8'h02, 2'h0},
    '{3'h0, 1'b0, 3'h4, 32'h3D2A7F9A, 8'h02, 8'h00, 2'h3},
    '{3'h0, 1'b1, 3'h3, 32'h3D2A7F00, 8'h02, 8'h02, 2'h0},
    '{3'h0, 1'b0, 3'h3, 32'h3D2A7FA9, 8'h02, 8'h00, 2'h0},
    '{3'h1, 1'b0, 3'h4, 32'h3D2A7FA9, 8'h06, 8'h04, 2'h0},
    '{3'h0, 1'b0, 3'h4, 32'h3D2A7F30, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h1, 32'h9B000000, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h4, 32'h53000000, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h4, 32'h55000000, 8'h04, 8'h04, 2'h3},
    '{3'h0, 1'b0, 3'h1, 32'hB9000000, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h1, 32'hAB000000, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h1, 32'h79000000, 8'h04, 8'h04, 2'h2},
    '{3'h0, 1'b0, 3'h1, 32'h11000000, 8'h04, 8'h04, 2'h3},
    '{3'h0, 1'b0, 3'h2, 32'hD0FF0000, 8'h07, 8'h01, 2'h3},
    '{3'h5, 1'b0, 3'h1, 32'hD0000000, 8'h15, 8'h11, 2'h3},
    '{3'h0, 1'b0, 3'h1, 32'hD0000000, 8'h11, 8'h01, 2'h3},
    '{3'h2, 1'b0, 3'h4, 32'h55000000, 8'h08, 8'h08, 2'h2},
    '{3'h4, 1'b0, 3'h4, 32'h53000000, 8'h18, 8'h18, 2'h3},
    '{3'h0, 1'b0, 3'h1, 32'hF0000000, 8'h1C, 8'h00, 2'h3}
  };
  // stimulus, all driven after a rising edge
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] susp_in = 3'h0;
  logic [7:0] prot_map = 8'h5A;
  logic [2:0] chk_sector = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wp_drive = 1'b0;
  logic pin_reset = 1'b0;
  // observed
  logic chk_blocked, cmd_pulse, cmd_accepted, soft_reset, irq, acc_seen;
  logic pd_enter, pd_leave;
  logic [2:0] seen = 3'h0;
  logic [ST_W-1:0] status;
  logic [7:0] cmd_op, op_seen;
  logic [31:0] rdata, rv;
  int failures = 0;
  int checked = 0;

  always #2 mclk = ~mclk;

  // link with the pull-up on write protect
  srsp_link_if link ();
  assign link.wp_n_in = link.wp_n_oe ? link.wp_n_out : 1'b1;

  srsp_dev #(.RESUME_CNT(RES_CNT), .SECTORS(8)) u_srsp_dev (
    .mclk, .rstn, .link(link.dev), .core_suspend_b1(susp_in[0]),
    .core_suspend_b2(susp_in[1]), .core_suspend_er(susp_in[2]),
    .prot_map, .chk_sector, .chk_blocked, .status, .cmd_pulse, .cmd_op,
    .cmd_accepted, .soft_reset, .pd_enter, .pd_leave);
  srsp_host #(.HALF_DIV(SCK_HALF_DIV)) u_srsp_host (
    .mclk, .rstn, .link(link.host), .addr, .wdata, .wr, .rd, .rdata,
    .wp_drive, .pin_reset, .irq);
  srsp_link_checker #(.HALF_DIV(SCK_HALF_DIV)) u_srsp_link_checker (
    .mclk, .rstn, .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .wp_n_in(link.wp_n_in), .wp_n_oe(link.wp_n_oe),
    .wp_n_out(link.wp_n_out), .rst_pin_n(link.rst_pin_n));

  // verdict of the last decoded frame
  always @(posedge mclk) begin
    // sticky record of {pd_leave, pd_enter, soft_reset}
    if (rstn === 1'b1) begin
      seen <= seen | {pd_leave, pd_enter, soft_reset};
    end
    if (cmd_pulse === 1'b1) begin
      acc_seen <= cmd_accepted;
      op_seen <= cmd_op;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic susp(input logic [2:0] s);
    @(posedge mclk);
    susp_in <= s;
    @(posedge mclk);
    susp_in <= 3'h0;
  endtask : susp

  // one frame; irq is the only completion sign
  task automatic send(input logic [2:0] n, input logic [31:0] w,
                      input logic ei);
    int k;
    acc_seen = 1'b0;
    wreg(RA_LEN, {29'h0, n});
    wreg(RA_CMD, w);
    for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, ei});
    if (ei) wreg(RA_IRQ, 32'h1);
    repeat (8) @(posedge mclk);
    #1;
  endtask : send

  task automatic idle();
    int k;
    for (k = 0; k < RES_CNT && status[ST_BUSY] !== 1'b0; k++) @(posedge mclk);
    #1 chk("busy", {31'h0, status[ST_BUSY]}, 32'h0);
  endtask : idle

  initial begin
    int p;
    int s;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1 chk("prot_reset", {31'h0, status[ST_PROT]}, 32'h0);
    wreg(RA_MASK, 32'h1);
    foreach (rows[i]) begin
      srsp_row_t r;
      r = rows[i];
      @(posedge mclk);
      wp_drive <= r.wp;
      susp(r.susp);
      send(r.len, r.w, 1'b1);
      chk("status", {24'h0, status & r.msk}, {24'h0, r.val});
      if (r.ac[1]) chk("accept", {31'h0, acc_seen}, {31'h0, r.ac[0]});
      if (r.ac == 2'h3) begin
        chk("op", {24'h0, op_seen}, {24'h0, r.w[31:24]});
      end
      idle();
    end
    // blocking follows the map only while enabled
    for (p = 0; p < 2; p++) begin
      send(3'h4, (p == 1) ? 32'h3D2A7F9A : 32'h3D2A7FA9, 1'b1);
      // status byte sent back during the frame, taken at select fall
      rreg(RA_RXD, rv);
      chk("rxd", rv, {30'h0, p == 1, 1'b0});
      for (s = 0; s < 8; s++) begin
        @(posedge mclk);
        chk_sector <= s[2:0];
        #1;
        chk("blocked", {31'h0, chk_blocked},
            {31'h0, prot_map[s] & (p == 0)});
      end
    end
    // only the soft reset pulsed; every power-down came while suspended
    chk("pulses", {29'h0, seen}, 32'h1);
    // power-down is acted on once nothing is suspended
    send(3'h1, {OP_DPD_ENTER, 24'h0}, 1'b1);
    chk("pd_enter", {29'h0, seen}, 32'h3);
    // suspend while resume still busy is dropped
    susp(3'h1);
    send(3'h1, {OP_RESUME, 24'h0}, 1'b1);
    send(3'h1, {OP_SUSPEND, 24'h0}, 1'b1);
    chk("suspend_busy", {31'h0, acc_seen}, 32'h0);
    idle();
    // pin reset clears pending suspends
    susp(3'h5);
    @(posedge mclk);
    pin_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    pin_reset <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("pin_reset", {24'h0, status & 8'h1C}, 32'h0);
    // masked event stays sticky, cleared by writing one
    wreg(RA_MASK, 32'h0);
    send(3'h1, {OP_RESUME, 24'h0}, 1'b0);
    rreg(RA_IRQ, rv);
    chk("ists_set", rv & 32'h1, 32'h1);
    wreg(RA_IRQ, 32'h1);
    rreg(RA_IRQ, rv);
    chk("ists_clr", rv & 32'h1, 32'h0);
    idle();
    report_and_stop();
  end

  // hang guard, well past the expected run length
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule : test_suspend_resume_sector_protect_cmds
